// File: rtl/rpmc_pkg.sv
// Shared constants and types for the receiver power-mode control block
package rpmc_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Serial link, rounded to the nearest whole cycle (0.2 % rate error)
  localparam int unsigned BAUD_BPS = 115_200;
  localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] HALF_BIT_LAST = 8'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0] FRAME_SHIFTS = 4'h9;
  localparam logic [3:0] STOP_INDEX = 4'h9;

  // Second pulse timing, in milliseconds and in cycles
  localparam int unsigned PULSE_PERIOD_MS = 1000;
  localparam int unsigned PULSE_WIDTH_MS = 100;
  localparam int unsigned CYCLES_PER_MS = 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * CYCLES_PER_MS;
  localparam int unsigned PULSE_WIDTH_CYCLES = PULSE_WIDTH_MS * CYCLES_PER_MS;
  localparam int unsigned PULSE_CNT_W = 25;

  // Command bytes of the control protocol
  localparam logic [7:0] CMD_PULSE_ON = 8'hA1;
  localparam logic [7:0] CMD_PULSE_OFF = 8'hA2;
  localparam logic [7:0] CMD_SLEEP = 8'hA3;
  localparam logic [7:0] CMD_STANDBY = 8'hA4;
  localparam logic [7:0] CMD_WAKE = 8'hA5;

  // Power states
  typedef enum logic [1:0] {
    PWR_ULP = 2'b00,
    PWR_FULL = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_STANDBY = 2'b11
  } rpmc_pwr_t;

  // Start types
  typedef enum logic [1:0] {
    START_COLD = 2'b00,
    START_WARM = 2'b01,
    START_HOT = 2'b10
  } rpmc_start_t;

  // Values after reset; the start type applies after power-on or supply reset, not the external pin
  localparam rpmc_pwr_t PWR_RESET_STATE = PWR_ULP;
  localparam rpmc_start_t START_RESET_TYPE = START_COLD;
  localparam logic PULSE_EN_RESET = 1'b0;

endpackage

// File: rtl/rpmc_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module rpmc_uart_tx
  import rpmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic tx_o
);

  logic [8:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] baud_cnt;

  wire accept = valid_i && ready_o;
  wire bit_done = (baud_cnt == 8'h00);

  // Start bit, eight data bits LSB first, one stop bit; line idles high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b1;
      tx_o <= 1'b1;
      shift <= 9'h1FF;
      bit_cnt <= 4'h0;
      baud_cnt <= 8'h00;
    end else if (accept) begin
      ready_o <= 1'b0;
      tx_o <= 1'b0;
      shift <= {1'b1, data_i};
      bit_cnt <= FRAME_SHIFTS;
      baud_cnt <= BIT_LAST;
    end else if (!ready_o) begin
      if (!bit_done) begin
        baud_cnt <= baud_cnt - 8'h01;
      end else if (bit_cnt != 4'h0) begin
        tx_o <= shift[0];
        shift <= {1'b1, shift[8:1]};
        bit_cnt <= bit_cnt - 4'h1;
        baud_cnt <= BIT_LAST;
      end else begin
        ready_o <= 1'b1; // Stop bit has stood a full bit time
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/rpmc_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module rpmc_uart_rx
  import rpmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  output logic [7:0] data_o,
  output logic valid_o
);

  logic active;
  logic [3:0] bit_cnt;
  logic [7:0] baud_cnt;
  logic [7:0] shift;

  wire sample = active && (baud_cnt == 8'h00);
  wire at_start = (bit_cnt == 4'h0);
  wire at_stop = (bit_cnt == STOP_INDEX);

  // Mid-bit sampling; a start bit gone high at its centre is a glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= 1'b0;
      bit_cnt <= 4'h0;
      baud_cnt <= 8'h00;
      shift <= 8'h00;
      data_o <= 8'h00;
      valid_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      if (!active) begin
        if (!rx_i) begin
          active <= 1'b1;
          bit_cnt <= 4'h0;
          baud_cnt <= HALF_BIT_LAST;
        end
      end else if (!sample) begin
        baud_cnt <= baud_cnt - 8'h01;
      end else begin
        baud_cnt <= BIT_LAST;
        bit_cnt <= bit_cnt + 4'h1;
        if (at_start && rx_i) begin
          active <= 1'b0;
        end else if (at_stop) begin
          active <= 1'b0;
          data_o <= shift;
          valid_o <= rx_i; // Framing error drops the byte silently
        end else if (!at_start) begin
          shift <= {rx_i, shift[7:1]};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/rpmc_receiver_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module rpmc_receiver_power_mode_control
  import rpmc_pkg::*;
#(
  parameter int unsigned PULSE_PERIOD = PULSE_PERIOD_CYCLES,
  parameter int unsigned PULSE_WIDTH = PULSE_WIDTH_CYCLES
)
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic EXT_RESET_N_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic FORCE_FULL_POWER_I,
  input wire logic SERIAL_RX_I,
  input wire logic [7:0] REPORT_DATA_I,
  input wire logic REPORT_VALID_I,
  input wire logic NAV_POS_VALID_I,
  input wire logic NAV_TIME_VALID_I,
  input wire logic NAV_ORBIT_VALID_I,
  output logic REPORT_READY_O,
  output logic SERIAL_TX_O,
  output logic AWAKE_INDICATOR_O,
  output logic [1:0] POWER_STATE_O,
  output logic SECOND_PULSE_O,
  output logic [1:0] START_TYPE_O,
  output logic HW_RESET_O
);

  // Reset sources
  // Supply loss and power-on clear everything, retained data included;
  // the external pin is a warm reset and leaves retained data alone.
  logic any_rst;
  logic power_rst;
  assign power_rst = RST_I || SUPPLY_LOW_I;
  assign any_rst = power_rst || !EXT_RESET_N_I;

  // Reset status, registered so the port comes from a flip-flop
  always_ff @(posedge REF_CLK_I) begin
    HW_RESET_O <= any_rst;
  end

  // Serial command receiver
  logic [7:0] cmd_byte;
  logic cmd_valid;

  rpmc_uart_rx u_cmd_rx (
    .clk_i(REF_CLK_I),
    .rst_i(any_rst),
    .rx_i(SERIAL_RX_I),
    .data_o(cmd_byte),
    .valid_o(cmd_valid)
  );

  // One decoder shared by every command strobe
  function automatic logic cmd_hit(input logic strobe, input logic [7:0] code,
    input logic [7:0] want);
    return strobe && (code == want);
  endfunction

  // Command decode; unknown bytes are dropped without a reply
  logic cmd_pulse_on;
  logic cmd_pulse_off;
  logic cmd_sleep;
  logic cmd_standby;
  logic cmd_wake;
  assign cmd_pulse_on = cmd_hit(cmd_valid, cmd_byte, CMD_PULSE_ON);
  assign cmd_pulse_off = cmd_hit(cmd_valid, cmd_byte, CMD_PULSE_OFF);
  assign cmd_sleep = cmd_hit(cmd_valid, cmd_byte, CMD_SLEEP);
  assign cmd_standby = cmd_hit(cmd_valid, cmd_byte, CMD_STANDBY);
  assign cmd_wake = cmd_hit(cmd_valid, cmd_byte, CMD_WAKE);

  // Report transmitter at the default link rate
  rpmc_uart_tx u_report_tx (
    .clk_i(REF_CLK_I),
    .rst_i(any_rst),
    .data_i(REPORT_DATA_I),
    .valid_i(REPORT_VALID_I),
    .ready_o(REPORT_READY_O),
    .tx_o(SERIAL_TX_O)
  );

  // Power state machine
  rpmc_pwr_t state;
  rpmc_pwr_t next_state;
  logic force_q;
  logic force_rise;

  assign force_rise = FORCE_FULL_POWER_I && !force_q;

  // Force edge history; cleared in reset so a held level counts as a rise
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      force_q <= 1'b0;
    end else begin
      force_q <= FORCE_FULL_POWER_I;
    end
  end

  // Force low always wins over any pending command
  always_comb begin
    next_state = state;
    unique case (state)
      PWR_ULP: begin
        if (FORCE_FULL_POWER_I) begin
          next_state = PWR_FULL;
        end
      end
      PWR_FULL: begin
        if (!FORCE_FULL_POWER_I) begin
          next_state = PWR_ULP;
        end else if (cmd_sleep) begin
          next_state = PWR_SLEEP;
        end else if (cmd_standby) begin
          next_state = PWR_STANDBY;
        end
      end
      PWR_SLEEP, PWR_STANDBY: begin
        if (!FORCE_FULL_POWER_I) begin
          next_state = PWR_ULP;
        end else if (force_rise || cmd_wake) begin
          next_state = PWR_FULL;
        end
      end
    endcase
  end

  // Awake level follows the state it is registered with
  logic next_awake;
  assign next_awake = (next_state == PWR_FULL) || (next_state == PWR_SLEEP);

  // State register; reset holds the initial state whatever force does
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      state <= PWR_RESET_STATE;
      AWAKE_INDICATOR_O <= 1'b0;
    end else begin
      state <= next_state;
      AWAKE_INDICATOR_O <= next_awake;
    end
  end

  // Power state reported as a plain code
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      POWER_STATE_O <= PWR_RESET_STATE;
    end else begin
      POWER_STATE_O <= next_state;
    end
  end

  // Second pulse enable
  // Off by default because the pulse driver costs supply current
  logic pulse_en;
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      pulse_en <= PULSE_EN_RESET;
    end else if (cmd_pulse_on) begin
      pulse_en <= 1'b1;
    end else if (cmd_pulse_off) begin
      pulse_en <= 1'b0;
    end
  end

  // Free-running second counter; keeps phase across enable changes
  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(PULSE_PERIOD - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_HIGH = PULSE_CNT_W'(PULSE_WIDTH);
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic pulse_wrap;
  logic pulse_window;
  assign pulse_wrap = (pulse_cnt == PULSE_LAST);
  assign pulse_window = (pulse_cnt < PULSE_HIGH);

  always_ff @(posedge REF_CLK_I) begin
    if (any_rst || pulse_wrap) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // Pulse only while enabled and awake in full power
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      SECOND_PULSE_O <= 1'b0;
    end else begin
      SECOND_PULSE_O <= pulse_en && pulse_window && (state == PWR_FULL);
    end
  end

  // Retained navigation data validity
  // Survives the external reset pin, lost with the supply.
  logic keep_pos;
  logic keep_time;
  logic keep_orbit;
  always_ff @(posedge REF_CLK_I) begin
    if (power_rst) begin
      keep_pos <= 1'b0;
      keep_time <= 1'b0;
      keep_orbit <= 1'b0;
    end else if (EXT_RESET_N_I) begin
      keep_pos <= NAV_POS_VALID_I;
      keep_time <= NAV_TIME_VALID_I;
      keep_orbit <= NAV_ORBIT_VALID_I;
    end
  end

  // Start type from what is retained
  logic have_pos_time;
  rpmc_start_t next_start;
  assign have_pos_time = keep_pos && keep_time;
  assign next_start = (have_pos_time && keep_orbit) ? START_HOT :
                      have_pos_time ? START_WARM : START_COLD;

  // Chosen while reset is held, frozen once the device runs;
  // a supply loss always forces the cold choice.
  always_ff @(posedge REF_CLK_I) begin
    if (power_rst) begin
      START_TYPE_O <= START_RESET_TYPE;
    end else if (!EXT_RESET_N_I) begin
      START_TYPE_O <= next_start;
    end
  end

endmodule
`default_nettype wire

// File: sim/rpmc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rpmc_properties
  import rpmc_pkg::*;
#(
  parameter int unsigned PULSE_PERIOD = PULSE_PERIOD_CYCLES,
  parameter int unsigned PULSE_WIDTH = PULSE_WIDTH_CYCLES
)
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic EXT_RESET_N_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic FORCE_FULL_POWER_I,
  input wire logic REPORT_VALID_I,
  input wire logic NAV_POS_VALID_I,
  input wire logic NAV_TIME_VALID_I,
  input wire logic NAV_ORBIT_VALID_I,
  input wire logic REPORT_READY_O,
  input wire logic SERIAL_TX_O,
  input wire logic AWAKE_INDICATOR_O,
  input wire logic [1:0] POWER_STATE_O,
  input wire logic SECOND_PULSE_O,
  input wire logic [1:0] START_TYPE_O,
  input wire logic HW_RESET_O
);
  // Reset sources; external pin alone keeps retained data
  wire logic rst_any = RST_I | ~EXT_RESET_N_I | SUPPLY_LOW_I;
  wire logic ext_only = ~EXT_RESET_N_I & ~RST_I & ~SUPPLY_LOW_I;
  logic [2:0] nav_q;
  int unsigned hi_cnt;
  wire logic [1:0] exp_st = (nav_q == 3'h7) ? START_HOT :
    ((nav_q[2:1] == 2'h3) ? START_WARM : START_COLD);
  // Mirror of retained validity, lost on power loss
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || SUPPLY_LOW_I)
      nav_q <= 3'h0;
    else if (EXT_RESET_N_I)
      nav_q <= {NAV_POS_VALID_I, NAV_TIME_VALID_I, NAV_ORBIT_VALID_I};
  end
  // Length of the pulse in progress
  always_ff @(posedge REF_CLK_I) begin
    hi_cnt <= SECOND_PULSE_O ? hi_cnt + 1 : 0;
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  awake_map_a: assert property (
    AWAKE_INDICATOR_O == (POWER_STATE_O inside {PWR_FULL, PWR_SLEEP}))
    else $error("awake level does not match power state");
  force_wake_a: assert property (
    !rst_any && FORCE_FULL_POWER_I && POWER_STATE_O == PWR_ULP |=> POWER_STATE_O == PWR_FULL)
    else $error("force high did not bring full power");
  ulp_force_a: assert property (!FORCE_FULL_POWER_I |=> POWER_STATE_O == PWR_ULP)
    else $error("force low did not give ultra low power");
  reset_hold_a: assert property (
    rst_any |=> POWER_STATE_O == PWR_ULP && !SECOND_PULSE_O && SERIAL_TX_O && REPORT_READY_O
      && HW_RESET_O)
    else $error("outputs not held during reset");
  supply_cold_a: assert property (
    SUPPLY_LOW_I |=> HW_RESET_O && START_TYPE_O == START_COLD)
    else $error("supply low did not reset to cold");
  tx_take_a: assert property (
    REPORT_VALID_I && REPORT_READY_O && !rst_any |=> !SERIAL_TX_O && !REPORT_READY_O)
    else $error("report byte not started");
  tx_idle_a: assert property (REPORT_READY_O |-> SERIAL_TX_O)
    else $error("transmit line low while idle");
  start_type_a: assert property (ext_only |=> START_TYPE_O == exp_st)
    else $error("start type does not follow retained data");
  pulse_width_a: assert property (hi_cnt <= PULSE_WIDTH)
    else $error("second pulse too long");
  cover property (POWER_STATE_O == PWR_SLEEP);
  cover property ($rose(SECOND_PULSE_O));
  cover property (START_TYPE_O == START_HOT);
endmodule
bind rpmc_receiver_power_mode_control rpmc_properties #(.PULSE_PERIOD(PULSE_PERIOD),
  .PULSE_WIDTH(PULSE_WIDTH)) props (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .EXT_RESET_N_I(EXT_RESET_N_I), .SUPPLY_LOW_I(SUPPLY_LOW_I),
  .FORCE_FULL_POWER_I(FORCE_FULL_POWER_I), .REPORT_VALID_I(REPORT_VALID_I),
  .NAV_POS_VALID_I(NAV_POS_VALID_I), .NAV_TIME_VALID_I(NAV_TIME_VALID_I),
  .NAV_ORBIT_VALID_I(NAV_ORBIT_VALID_I), .REPORT_READY_O(REPORT_READY_O),
  .SERIAL_TX_O(SERIAL_TX_O), .AWAKE_INDICATOR_O(AWAKE_INDICATOR_O),
  .POWER_STATE_O(POWER_STATE_O), .SECOND_PULSE_O(SECOND_PULSE_O),
  .START_TYPE_O(START_TYPE_O), .HW_RESET_O(HW_RESET_O));
`default_nettype wire

// File: sim/rpmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpmc_host_model
  import rpmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  // Command line idles high between frames
  initial begin
    rx_o = 1'b1;
  end
  // One 8N1 command frame, LSB first, changed just after an edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o = f[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
      #1;
    end
  endtask
  // Report frame sampled at bit centres; gives stop and data
  task automatic recv_byte(output logic [8:0] r);
    @(negedge tx_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      #1;
      r[i] = tx_i;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rpmc_pkg::*;
  // Short pulse counts keep the run brief
  localparam int unsigned PP = 100;
  localparam int unsigned PW = 10;
  localparam logic [7:0] CMDS [4] = '{CMD_SLEEP, CMD_WAKE, CMD_STANDBY, CMD_WAKE};
  localparam rpmc_pwr_t STS [4] = '{PWR_SLEEP, PWR_FULL, PWR_STANDBY, PWR_FULL};
  logic clk, rst, ext_n, sup_low, force_hi, rep_valid, pos_v, time_v, orb_v;
  logic [7:0] rep_data;
  wire logic rx, tx_line, ready, awake, pulse, hw_rst;
  wire logic [1:0] pstate, stype;
  int errors, cmp_count;
  rpmc_receiver_power_mode_control #(.PULSE_PERIOD(PP), .PULSE_WIDTH(PW)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .EXT_RESET_N_I(ext_n), .SUPPLY_LOW_I(sup_low),
    .FORCE_FULL_POWER_I(force_hi), .SERIAL_RX_I(rx), .REPORT_DATA_I(rep_data),
    .REPORT_VALID_I(rep_valid), .NAV_POS_VALID_I(pos_v), .NAV_TIME_VALID_I(time_v),
    .NAV_ORBIT_VALID_I(orb_v), .REPORT_READY_O(ready), .SERIAL_TX_O(tx_line),
    .AWAKE_INDICATOR_O(awake), .POWER_STATE_O(pstate), .SECOND_PULSE_O(pulse),
    .START_TYPE_O(stype), .HW_RESET_O(hw_rst));
  rpmc_host_model host (.clk_i(clk), .tx_i(tx_line), .rx_o(rx));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Inputs move just after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic results();
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // High cycles of the pulse over one period
  task automatic count_pulse(output int hi);
    hi = 0;
    repeat (PP) begin
      step(1);
      hi += int'(pulse);
    end
  endtask
  task automatic t_reset();
    chk(9'(PWR_ULP), 9'(pstate));
    chk(9'h0, 9'({awake, pulse}));
    chk(9'h3, 9'({tx_line, ready}));
    chk(9'(START_COLD), 9'(stype));
  endtask
  task automatic t_force();
    force_hi = 1'b1;
    step(1);
    chk(9'(PWR_FULL), 9'(pstate));
    chk(9'h1, 9'(awake));
    force_hi = 1'b0;
    step(1);
    chk(9'(PWR_ULP), 9'(pstate));
    chk(9'h0, 9'(awake));
    force_hi = 1'b1;
    step(1);
  endtask
  task automatic t_cmds();
    for (int i = 0; i < 4; i++) begin
      host.send_byte(CMDS[i]);
      step(2);
      chk(9'(STS[i]), 9'(pstate));
      chk(9'(STS[i] != PWR_STANDBY), 9'(awake));
    end
  endtask
  task automatic t_pulse();
    int hi;
    count_pulse(hi);
    chk(9'h0, 9'(hi));
    host.send_byte(CMD_PULSE_ON);
    step(2);
    count_pulse(hi);
    chk(9'(PW), 9'(hi));
    host.send_byte(CMD_PULSE_OFF);
    step(2);
    count_pulse(hi);
    chk(9'h0, 9'(hi));
  endtask
  task automatic t_report();
    logic [8:0] r;
    rep_data = 8'h4D;
    fork
      host.recv_byte(r);
      begin
        rep_valid = 1'b1;
        step(1);
        rep_valid = 1'b0;
      end
    join
    chk(9'h14D, r);
    step(BIT_CYCLES);
    chk(9'h3, 9'({tx_line, ready}));
  endtask
  task automatic t_start();
    {pos_v, time_v, orb_v} = 3'h7;
    step(1);
    ext_n = 1'b0;
    step(2);
    chk(9'(START_HOT), 9'(stype));
    chk(9'(PWR_ULP), 9'(pstate));
    chk(9'h1, 9'(hw_rst));
    orb_v = 1'b0;
    ext_n = 1'b1;
    step(2);
    ext_n = 1'b0;
    step(2);
    chk(9'(START_WARM), 9'(stype));
    ext_n = 1'b1;
    sup_low = 1'b1;
    step(2);
    chk(9'(START_COLD), 9'(stype));
    chk(9'h1, 9'(hw_rst));
    sup_low = 1'b0;
    step(1);
  endtask
  initial begin
    {rst, ext_n, sup_low, force_hi, rep_valid} = 5'h18;
    {pos_v, time_v, orb_v} = 3'h0;
    rep_data = 8'h00;
    errors = 0;
    cmp_count = 0;
    step(8);
    rst = 1'b0;
    step(1);
    t_reset();
    t_force();
    t_cmds();
    t_pulse();
    t_report();
    t_start();
    results();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
